// >>> design/completion_event_gen.sv
// Completion event generator for one transfer ring, with APB registers.

module completion_event_gen
#(
    parameter int LW = evgen_pkg::LEN_W,
    parameter int JW = evgen_pkg::JOB_W,
    parameter int MW = evgen_pkg::MPS_W,
    parameter int AW = evgen_pkg::ADDR_W
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   resetn_i,
    // APB slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [evgen_pkg::PA_W-1:0] paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Completed ring entries from the transfer engine
    input  wire logic                   ent_valid_i,
    output logic                        ent_ready_o,
    input  wire evgen_pkg::kind_t       ent_kind_i,
    input  wire logic                   completion_notify_flag_i,
    input  wire logic                   short_notify_flag_i,
    input  wire logic                   parse_all_markers_flag_i,
    input  wire logic [LW-1:0]          ent_len_i,
    input  wire logic [LW-1:0]          ent_residue_i,
    input  wire logic                   ent_short_i,
    input  wire logic [7:0]             ent_err_i,
    input  wire logic                   ent_last_i,
    input  wire logic                   ent_isoch_i,
    input  wire logic [AW-1:0]          ent_addr_i,
    input  wire logic [7:0]             ent_slot_i,
    input  wire logic [4:0]             ent_ep_i,
    input  wire logic                   ring_end_i,
    // Completion events toward the event ring writer
    output logic                        ev_valid_o,
    input  wire logic                   ev_ready_i,
    input  wire logic                   ev_sink_full_i,
    output logic      [7:0]             ev_code_o,
    output logic      [JW-1:0]          ev_len_o,
    output logic      [AW-1:0]          ev_addr_o,
    output logic      [7:0]             ev_slot_o,
    output logic      [4:0]             ev_ep_o,
    output logic                        ev_marker_o,
    output logic                        irq_o,
    output logic                        ep_halted_o,
    // IN packet scheduler
    output logic                        pkt_req_o,
    output logic      [MW-1:0]          pkt_size_o,
    input  wire logic                   pkt_ready_i,
    input  wire logic                   rx_valid_i,
    input  wire logic [MW-1:0]          rx_bytes_i
);
    import evgen_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        mode_t           mode;
        logic            marker_seen;
        logic            pend_bnd;
        logic            lost;
        logic            halted;
        logic [JW-1:0]   accum;
        logic            ev_valid;
        logic [7:0]      ev_code;
        logic [JW-1:0]   ev_len;
        logic [AW-1:0]   ev_addr;
        logic [7:0]      ev_slot;
        logic [4:0]      ev_ep;
        logic            ev_marker;
        logic            irq;
        logic            ent_ready;
        logic            enable;
        logic [MW-1:0]   mps;
        logic [JW-1:0]   rem;
        logic [JW-1:0]   pkt_cnt;
        logic            busy;
        logic            pkt_req;
        logic [MW-1:0]   pkt_size;
        logic            short_rx;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } state_t;

    localparam state_t STATE_RST = '{
        mode:     MODE_RUN,
        mps:      MPS_RST,
        ev_code:  CC_NONE,
        default:  '0
    };

    state_t s_r;
    state_t s_nxt;
    logic [1:0] rst_sync_r;
    logic       rst_n;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Assertion is immediate; release waits two clock edges.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic          setup;
        logic          wr;
        logic          got;
        logic          emit;
        logic [7:0]    e_code;
        logic [JW-1:0] e_len;
        logic          e_mark;
        logic [JW-1:0] moved;
        logic [JW-1:0] step;
        s_nxt  = s_r;
        setup  = psel_i & ~penable_i;
        wr     = psel_i & penable_i & s_r.pready & pwrite_i
                 & ~s_r.pslverr;
        got    = ent_valid_i & s_r.ent_ready;
        emit   = 1'b0;
        e_code = CC_NONE;
        e_len  = '0;
        e_mark = 1'b0;
        moved  = ent_short_i ? JW'(ent_len_i - ent_residue_i)
                             : JW'(ent_len_i);
        step   = '0;
        s_nxt.irq     = 1'b0;
        s_nxt.pkt_req = 1'b0;

        // APB answers one cycle after the setup cycle.
        s_nxt.pready  = setup;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = '0;
        if (setup) begin
            case (paddr_i)
                REG_CTRL: begin
                    s_nxt.prdata[CTRL_ENABLE] = s_r.enable;
                end
                REG_STATUS: begin
                    s_nxt.prdata[STAT_HALTED] = s_r.halted;
                    s_nxt.prdata[STAT_SKIP]   =
                        (s_r.mode == MODE_SHORT_SKIP);
                    s_nxt.prdata[STAT_PEND]   = s_r.pend_bnd;
                    s_nxt.prdata[STAT_LOST]   = s_r.lost;
                    s_nxt.prdata[STAT_SHRT]   = s_r.short_rx;
                    s_nxt.prdata[STAT_BUSY]   = s_r.busy;
                    s_nxt.prdata[STAT_ERRSK]  =
                        (s_r.mode == MODE_ERR_SKIP);
                end
                REG_MPS:    s_nxt.prdata = 32'(s_r.mps);
                REG_JOBSZ:  s_nxt.prdata = 32'(s_r.rem);
                REG_PKTCNT: s_nxt.prdata = 32'(s_r.pkt_cnt);
                default:    s_nxt.pslverr = 1'b1;
            endcase
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (wr && paddr_i == REG_CTRL) begin
            s_nxt.enable = pwdata_i[CTRL_ENABLE];
            if (pwdata_i[CTRL_CLR_SHRT]) begin
                s_nxt.short_rx = 1'b0;
            end
            // Software moves the ring on; the new position is a job start.
            if (pwdata_i[CTRL_REPOS]) begin
                s_nxt.mode        = MODE_RUN;
                s_nxt.halted      = 1'b0;
                s_nxt.pend_bnd    = 1'b0;
                s_nxt.lost        = 1'b0;
                s_nxt.accum       = '0;
                s_nxt.marker_seen = 1'b0;
            end else if (pwdata_i[CTRL_DOORBELL]) begin
                s_nxt.pend_bnd = 1'b0;
            end
        end
        if (wr && paddr_i == REG_MPS) begin
            s_nxt.mps = pwdata_i[MW-1:0];
        end

        // ----------------------------------------
        // IN packet scheduler
        // ----------------------------------------
        // A zero max packet size would never finish, so it starts nothing.
        if (wr && paddr_i == REG_JOBSZ) begin
            s_nxt.rem     = pwdata_i[JW-1:0];
            s_nxt.pkt_cnt = '0;
            s_nxt.busy    = (pwdata_i[JW-1:0] != '0)
                            && (s_r.mps != '0);
        end else if (s_r.busy && pkt_ready_i) begin
            step = (s_r.rem > JW'(s_r.mps)) ? JW'(s_r.mps)
                                            : s_r.rem;
            s_nxt.pkt_req  = 1'b1;
            s_nxt.pkt_size = step[MW-1:0];
            s_nxt.rem      = s_r.rem - step;
            s_nxt.pkt_cnt  = s_r.pkt_cnt + JW'(1);
            s_nxt.busy     = (s_r.rem > JW'(s_r.mps));
        end
        // Detection beats a clear in the same cycle.
        if (rx_valid_i && rx_bytes_i < s_r.pkt_size) begin
            s_nxt.short_rx = 1'b1;
        end

        // ----------------------------------------
        // Event slot drain
        // ----------------------------------------
        if (s_r.ev_valid && ev_ready_i) begin
            s_nxt.ev_valid = 1'b0;
            s_nxt.irq      = 1'b1;
        end

        // ----------------------------------------
        // Entry evaluation
        // ----------------------------------------
        if (got) begin
            case (s_r.mode)
                MODE_RUN: begin
                    case (ent_kind_i)
                        KIND_MARKER: begin
                            if (completion_notify_flag_i) begin
                                emit   = 1'b1;
                                e_code = CC_SUCCESS;
                                e_len  = s_r.accum;
                                e_mark = 1'b1;
                            end
                            s_nxt.accum = '0;
                        end
                        KIND_CHAIN: begin
                            if (completion_notify_flag_i) begin
                                emit   = 1'b1;
                                e_code = CC_SUCCESS;
                            end
                        end
                        default: begin
                            s_nxt.accum = s_r.accum + moved;
                            if (ent_err_i != CC_NONE) begin
                                emit   = 1'b1;
                                e_code = ent_err_i;
                                e_len  = JW'(ent_residue_i);
                                if (!ent_isoch_i) begin
                                    s_nxt.mode   = MODE_HALT;
                                    s_nxt.halted = 1'b1;
                                end else if (ent_err_i == CC_MISSED
                                             && !ent_last_i) begin
                                    s_nxt.mode = MODE_ERR_SKIP;
                                end
                            end else if (ent_short_i) begin
                                if (short_notify_flag_i
                                    || completion_notify_flag_i) begin
                                    emit   = 1'b1;
                                    e_code = CC_SHORT;
                                    e_len  = JW'(ent_residue_i);
                                end
                                if (!ent_last_i) begin
                                    s_nxt.mode = MODE_SHORT_SKIP;
                                    s_nxt.marker_seen = 1'b0;
                                end
                            end else if (completion_notify_flag_i) begin
                                emit   = 1'b1;
                                e_code = CC_SUCCESS;
                            end
                        end
                    endcase
                    if (ent_last_i) begin
                        s_nxt.accum = '0;
                    end
                end
                MODE_SHORT_SKIP: begin
                    if (ent_kind_i == KIND_MARKER) begin
                        if (completion_notify_flag_i
                            && (!s_r.marker_seen
                                || parse_all_markers_flag_i)) begin
                            emit   = 1'b1;
                            e_code = CC_SHORT;
                            e_len  = s_r.accum;
                            e_mark = 1'b1;
                        end
                        s_nxt.marker_seen = 1'b1;
                        s_nxt.accum       = '0;
                    end else if (ent_kind_i == KIND_CHAIN
                                 && completion_notify_flag_i) begin
                        emit   = 1'b1;
                        e_code = CC_SUCCESS;
                    end
                    if (ent_last_i) begin
                        s_nxt.mode  = MODE_RUN;
                        s_nxt.accum = '0;
                    end
                end
                MODE_ERR_SKIP: begin
                    if (ent_last_i) begin
                        s_nxt.mode  = MODE_RUN;
                        s_nxt.accum = '0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Enqueue reached while skipping to a job boundary after a missed isoch entry.
        if (ring_end_i && s_r.mode == MODE_ERR_SKIP) begin
            s_nxt.pend_bnd = 1'b1;
        end

        // ----------------------------------------
        // Event load
        // ----------------------------------------
        // One slot keeps events in entry order; a full ring loses it.
        if (emit) begin
            if (ev_sink_full_i) begin
                s_nxt.lost   = 1'b1;
                s_nxt.halted = 1'b1;
                s_nxt.mode   = MODE_HALT;
            end else begin
                s_nxt.ev_valid  = 1'b1;
                s_nxt.ev_code   = e_code;
                s_nxt.ev_len    = e_len;
                s_nxt.ev_addr   = ent_addr_i;
                s_nxt.ev_slot   = ent_slot_i;
                s_nxt.ev_ep     = ent_ep_i;
                s_nxt.ev_marker = e_mark;
            end
        end

        // Entries wait while an event is pending or the ring is held.
        s_nxt.ent_ready = s_nxt.enable && !s_nxt.ev_valid
                          && s_nxt.mode != MODE_HALT
                          && !s_nxt.pend_bnd
                          && !(got && emit);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata_o    = s_r.prdata;
    assign pready_o    = s_r.pready;
    assign pslverr_o   = s_r.pslverr;
    assign ent_ready_o = s_r.ent_ready;
    assign ev_valid_o  = s_r.ev_valid;
    assign ev_code_o   = s_r.ev_code;
    assign ev_len_o    = s_r.ev_len;
    assign ev_addr_o   = s_r.ev_addr;
    assign ev_slot_o   = s_r.ev_slot;
    assign ev_ep_o     = s_r.ev_ep;
    assign ev_marker_o = s_r.ev_marker;
    assign irq_o       = s_r.irq;
    assign ep_halted_o = s_r.halted;
    assign pkt_req_o   = s_r.pkt_req;
    assign pkt_size_o  = s_r.pkt_size;

endmodule

// >>> design/evgen_pkg.sv
// Constants and types shared by the completion event generator.
package evgen_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int LEN_W  = 17;
    localparam int JOB_W  = 24;
    localparam int MPS_W  = 11;
    localparam int ADDR_W = 64;
    localparam int PA_W   = 8;

    // ------------------------------------------------------------
    // Completion codes carried by events
    // ------------------------------------------------------------
    localparam logic [7:0] CC_NONE    = 8'h00;
    localparam logic [7:0] CC_SUCCESS = 8'h01;
    localparam logic [7:0] CC_SHORT   = 8'h02;
    localparam logic [7:0] CC_MISSED  = 8'h03;
    localparam logic [7:0] CC_LOST    = 8'h04;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [PA_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [PA_W-1:0] REG_STATUS = 8'h04;
    localparam logic [PA_W-1:0] REG_MPS    = 8'h08;
    localparam logic [PA_W-1:0] REG_JOBSZ  = 8'h0c;
    localparam logic [PA_W-1:0] REG_PKTCNT = 8'h10;

    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_REPOS    = 1;
    localparam int CTRL_DOORBELL = 2;
    localparam int CTRL_CLR_SHRT = 3;

    localparam int STAT_HALTED = 0;
    localparam int STAT_SKIP   = 1;
    localparam int STAT_PEND   = 2;
    localparam int STAT_LOST   = 3;
    localparam int STAT_SHRT   = 4;
    localparam int STAT_BUSY   = 5;
    localparam int STAT_ERRSK  = 6;

    localparam logic [MPS_W-1:0] MPS_RST = 11'h200;

    // ------------------------------------------------------------
    // Entry kinds and processing modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_MARKER,
        KIND_CHAIN
    } kind_t;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SHORT_SKIP,
        MODE_ERR_SKIP,
        MODE_HALT
    } mode_t;

endpackage

// >>> testbench/evgen_props.sv
// Port-level assertions for the completion event generator.
module evgen_props
    import evgen_pkg::*;
#(
    parameter int LW = LEN_W,
    parameter int JW = JOB_W,
    parameter int AW = ADDR_W
) (
    input wire logic             core_clk_i,
    input wire logic             resetn_i,
    input wire logic             psel_i,
    input wire logic             penable_i,
    input wire logic             pready_o,
    input wire logic             ent_valid_i,
    input wire logic             ent_ready_o,
    input wire evgen_pkg::kind_t ent_kind_i,
    input wire logic             completion_notify_flag_i,
    input wire logic             short_notify_flag_i,
    input wire logic [LW-1:0]    ent_residue_i,
    input wire logic             ent_short_i,
    input wire logic [7:0]       ent_err_i,
    input wire logic             ent_isoch_i,
    input wire logic [AW-1:0]    ent_addr_i,
    input wire logic [7:0]       ent_slot_i,
    input wire logic             ev_valid_o,
    input wire logic             ev_ready_i,
    input wire logic             ev_sink_full_i,
    input wire logic [7:0]       ev_code_o,
    input wire logic [JW-1:0]    ev_len_o,
    input wire logic [AW-1:0]    ev_addr_o,
    input wire logic [7:0]       ev_slot_o,
    input wire logic             irq_o,
    input wire logic             ep_halted_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_err;
        ent_valid_i && ent_ready_o && ent_err_i != CC_NONE;
    endsequence
    sequence s_short;
        ent_valid_i && ent_ready_o && ent_short_i && short_notify_flag_i
            && ent_kind_i == KIND_NORMAL && ent_err_i == CC_NONE;
    endsequence
    a_apb_answer: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no answer");
    a_apb_single: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    a_irq_follows: assert property (
        irq_o |-> $past(ev_valid_o && ev_ready_i))
        else $error("stray interrupt");
    a_hold_event: assert property (
        ev_valid_o && !ev_ready_i |=> ev_valid_o && $stable(ev_code_o)
        && $stable(ev_len_o) && $stable(ev_addr_o))
        else $error("event changed");
    a_ready_gated: assert property (ev_valid_o |-> !ent_ready_o)
        else $error("entry taken early");
    a_err_event: assert property (
        s_err ##0 !ev_sink_full_i |=> ev_valid_o
        && ev_code_o == $past(ent_err_i) && ev_addr_o == $past(ent_addr_i)
        && ev_slot_o == $past(ent_slot_i))
        else $error("no error event");
    a_short_event: assert property (
        s_short ##0 !ev_sink_full_i |=> ev_valid_o
        && ev_code_o == CC_SHORT && ev_len_o == $past(ent_residue_i))
        else $error("bad short event");
    a_quiet_entry: assert property (
        ent_valid_i && ent_ready_o && ent_kind_i == KIND_NORMAL
        && !completion_notify_flag_i && !short_notify_flag_i
        && ent_err_i == CC_NONE |=> !ev_valid_o)
        else $error("event without cause");
    a_err_halt: assert property (
        s_err ##0 !ent_isoch_i |-> ##[1:2] ep_halted_o)
        else $error("no halt on error");
    a_lost_halt: assert property (
        s_err ##0 ev_sink_full_i |-> ##[1:2] ep_halted_o)
        else $error("no halt on loss");
endmodule

// >>> testbench/evgen_sink.sv
// Event ring writer model that takes each event after a set wait.
module evgen_sink (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ev_valid_i,
    input  wire logic [3:0] wait_i,
    input  wire logic       full_i,
    output logic            ev_ready_o,
    output logic            ev_sink_full_o,
    output logic [7:0]      ev_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // Ready is a one-cycle grant, so one event is never counted twice.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {ev_ready_o, ev_sink_full_o, cnt_r, ev_count_o} <= '0;
        end else begin
            ev_sink_full_o <= full_i;
            if (ev_ready_o) begin
                ev_ready_o <= 1'b0;
                cnt_r <= 4'h0;
                ev_count_o <= ev_count_o + 8'h01;
            end else if (ev_valid_i && cnt_r >= wait_i) begin
                ev_ready_o <= 1'b1;
            end else if (ev_valid_i) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the completion event generator.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import evgen_pkg::*;
    logic core_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o;
    logic pslverr_o, ent_valid_i, ent_ready_o, ent_short_i, ent_last_i;
    logic completion_notify_flag_i, short_notify_flag_i, ent_isoch_i;
    logic parse_all_markers_flag_i, ring_end_i, ev_valid_o, ev_ready_i;
    logic ev_sink_full_i, ev_marker_o, irq_o, ep_halted_o, pkt_req_o;
    logic pkt_ready_i, rx_valid_i, sink_full, perr;
    logic [7:0] paddr_i, ent_err_i, ent_slot_i, ev_code_o, ev_slot_o, seq;
    logic [7:0] ev_count, irq_cnt;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [LEN_W-1:0] ent_len_i, ent_residue_i;
    logic [JOB_W-1:0] ev_len_o;
    logic [ADDR_W-1:0] ent_addr_i, ev_addr_o;
    logic [4:0] ent_ep_i, ev_ep_o;
    logic [MPS_W-1:0] pkt_size_o, rx_bytes_i;
    logic [MPS_W-1:0] pkts[$];
    logic [3:0] sink_wait;
    kind_t ent_kind_i;
    int bad_count, checked, cyc;
    completion_event_gen i_completion_event_gen (.*);
    evgen_sink i_evgen_sink (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .ev_valid_i(ev_valid_o), .wait_i(sink_wait), .full_i(sink_full),
        .ev_ready_o(ev_ready_i), .ev_sink_full_o(ev_sink_full_i),
        .ev_count_o(ev_count));
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (pkt_req_o === 1'b1) pkts.push_back(pkt_size_o);
        if (irq_o === 1'b1) irq_cnt <= irq_cnt + 8'h01;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [63:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %0t: %0h vs %0h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge core_clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        perr = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic ent(input kind_t k, input logic [4:0] f,
            input logic [LEN_W-1:0] ln, rs, input logic [7:0] er, xc,
            input logic [JOB_W-1:0] xl);
        @(posedge core_clk_i);
        {ent_valid_i, ent_kind_i, ent_len_i, ent_residue_i}
            <= {1'b1, k, ln, rs};
        {completion_notify_flag_i, short_notify_flag_i,
            parse_all_markers_flag_i, ent_short_i, ent_last_i} <= f;
        {ent_err_i, ent_addr_i, ent_slot_i, ent_ep_i}
            <= {er, seq, 48'h0, seq, seq, seq[4:0]};
        do @(posedge core_clk_i); while (ent_ready_o !== 1'b1);
        ent_valid_i <= 1'b0;
        @(negedge core_clk_i);
        chk(ev_valid_o, xc != CC_NONE);
        if (xc != CC_NONE) begin
            chk({ev_code_o, ev_len_o}, {xc, xl});
            chk(ev_addr_o, {seq, 48'h0, seq});
            chk({ev_slot_o, ev_ep_o, ev_marker_o},
                {seq, seq[4:0], k == KIND_MARKER});
        end
        while (ev_valid_o === 1'b1) @(negedge core_clk_i);
        seq = seq + 8'h01;
    endtask
    task automatic final_report();
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic run_job();
        sink_wait <= 4'h2;
        ent(KIND_NORMAL, 5'b00000, 10, 0, 0, CC_NONE, 0);
        ent(KIND_NORMAL, 5'b10000, 6, 0, 0, CC_SUCCESS, 0);
        ent(KIND_MARKER, 5'b10000, 0, 0, 0, CC_SUCCESS, 16);
        ent(KIND_MARKER, 5'b10001, 0, 0, 0, CC_SUCCESS, 0);
    endtask
    task automatic short_job();
        ent(KIND_NORMAL, 5'b00010, 8, 3, 0, CC_NONE, 0);
        ent(KIND_CHAIN, 5'b10000, 0, 0, 0, CC_SUCCESS, 0);
        ent(KIND_MARKER, 5'b10000, 0, 0, 0, CC_SHORT, 5);
        ent(KIND_MARKER, 5'b10001, 0, 0, 0, CC_NONE, 0);
        ent(KIND_NORMAL, 5'b01010, 10, 4, 0, CC_SHORT, 4);
        ent(KIND_NORMAL, 5'b10000, 7, 0, 0, CC_NONE, 0);
        ent(KIND_MARKER, 5'b10000, 0, 0, 0, CC_SHORT, 6);
        ent(KIND_MARKER, 5'b10101, 0, 0, 0, CC_SHORT, 0);
        ent(KIND_NORMAL, 5'b10001, 3, 0, 0, CC_SUCCESS, 0);
    endtask
    task automatic err_job();
        for (int i = 0; i < 2; i++) begin
            ent_isoch_i <= i[0];
            ent(KIND_NORMAL, 5'h0, 9, 9, CC_MISSED, CC_MISSED, 9);
            chk({ent_ready_o, ep_halted_o}, {i[0], !i[0]});
            @(posedge core_clk_i);
            ring_end_i <= i[0];
            @(posedge core_clk_i);
            ring_end_i <= 1'b0;
            apb(1'b0, REG_STATUS, 32'h0);
            chk(rd[STAT_HALTED], !i[0]);
            chk({rd[STAT_PEND], rd[STAT_ERRSK]}, {i[0], i[0]});
            apb(1'b1, REG_CTRL, 32'h3);
            repeat (2) @(negedge core_clk_i);
            chk(ep_halted_o, 1'b0);
        end
        ent_isoch_i <= 1'b0;
    endtask
    task automatic lost_job();
        sink_full <= 1'b1;
        ent(KIND_NORMAL, 5'b10000, 4, 4, CC_MISSED, CC_NONE, 0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk({rd[STAT_LOST], rd[STAT_HALTED]}, 2'b11);
        sink_full <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h3);
    endtask
    task automatic sched_job();
        apb(1'b1, REG_MPS, 32'h2);
        apb(1'b1, REG_JOBSZ, 32'h5);
        repeat (8) @(posedge core_clk_i);
        chk(pkts.size(), 3);
        chk({pkts[0], pkts[1], pkts[2]}, {11'd2, 11'd2, 11'd1});
        apb(1'b0, REG_PKTCNT, 32'h0);
        chk(rd, 32'd3);
        {rx_valid_i, rx_bytes_i} <= {1'b1, 11'd0};
        @(posedge core_clk_i);
        rx_valid_i <= 1'b0;
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[STAT_SHRT], 1'b1);
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, resetn_i} = '0;
        {ent_valid_i, ent_len_i, ent_residue_i, ent_err_i, ent_addr_i} = '0;
        {completion_notify_flag_i, short_notify_flag_i, ent_isoch_i} = '0;
        {parse_all_markers_flag_i, ent_short_i, ent_last_i} = '0;
        {ent_slot_i, ent_ep_i, ring_end_i, rx_valid_i, rx_bytes_i} = '0;
        {sink_full, sink_wait, irq_cnt, pkt_ready_i, seq} = {13'h0, 9'h101};
        ent_kind_i = KIND_NORMAL;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        apb(1'b0, REG_MPS, 32'h0);
        chk(rd, MPS_RST);
        apb(1'b0, 8'h40, 32'h0);
        chk(perr, 1'b1);
        apb(1'b1, REG_CTRL, 32'h1);
        run_job();
        short_job();
        err_job();
        lost_job();
        sched_job();
        repeat (4) @(posedge core_clk_i);
        chk(irq_cnt, ev_count);
        final_report();
    end
endmodule
bind completion_event_gen evgen_props #(.LW(LW), .JW(JW), .AW(AW))
    i_evgen_props (.*);
